/* core/scb_pkg.sv */
// Constants, types and helpers for the SDRAM command pin block
package scb_pkg;
    localparam int ADDR_W          = 12;
    localparam int DATA_W          = 16;
    localparam int COL_W           = 8;
    localparam int BANK_W          = 2;
    localparam int BANKS           = 4;
    localparam int LEN_W           = 9;
    localparam int READ_STAGES     = 2;
    localparam int SCOPE_BIT       = 10;
    localparam int MODE_LEN_LSB    = 0;
    localparam int MODE_TYPE_BIT   = 3;
    localparam int MODE_LAT_LSB    = 4;
    localparam int MODE_SINGLE_BIT = 9;

    localparam logic [11:0] MODE_RESET = 12'h030;
    localparam logic [2:0]  LAT_TWO    = 3'h2;
    localparam logic [8:0]  LEN_ONE    = 9'h001;
    localparam logic [8:0]  LEN_FULL   = 9'h100;

    // Strobe codes, row/column/write, all active low
    localparam logic [2:0] CMD_LOAD_MODE  = 3'h0;
    localparam logic [2:0] CMD_REFRESH    = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE  = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE   = 3'h3;
    localparam logic [2:0] CMD_WRITE      = 3'h4;
    localparam logic [2:0] CMD_READ       = 3'h5;
    localparam logic [2:0] CMD_BURST_STOP = 3'h6;

    typedef enum logic [3:0] {
        ST_RUN          = 4'h1,
        ST_POWER_DOWN   = 4'h2,
        ST_SUSPEND      = 4'h4,
        ST_SELF_REFRESH = 4'h8
    } scb_state_type;

    typedef struct packed {
        logic              select_n;
        logic              row_n;
        logic              col_n;
        logic              write_n;
        logic [ADDR_W-1:0] address;
        logic              bank_high;
        logic              bank_low;
        logic              high_mask;
        logic              low_mask;
        logic [DATA_W-1:0] data;
    } scb_pins_type;

    localparam scb_pins_type PINS_IDLE = scb_pins_type'({4'hF, 32'h0});

    function automatic logic [8:0] scb_burst_len(input logic [2:0] code);
        case (code)
            3'h0:    return LEN_ONE;
            3'h1:    return 9'h002;
            3'h2:    return 9'h004;
            3'h3:    return 9'h008;
            3'h7:    return LEN_FULL;
            default: return LEN_ONE;
        endcase
    endfunction
endpackage

/* core/scb_bank_if.sv */
// Bank open/close requests and per-bank row state
interface scb_bank_if;
    logic        activate;
    logic        precharge;
    logic        all_banks;
    logic [1:0]  bank;
    logic [11:0] row;
    logic        auto_precharge;
    logic [1:0]  auto_bank;
    logic [3:0]  active;
    logic [11:0] open_row [4];

    modport cmd_side (output activate, precharge, all_banks, bank, row,
                      output auto_precharge, auto_bank,
                      input active, open_row);
    modport bank_side (input activate, precharge, all_banks, bank, row,
                       input auto_precharge, auto_bank,
                       output active, open_row);
endinterface

/* core/scb_bank_table.sv */
// Per-bank open flag and open row
module scb_bank_table (
    input wire logic   i_clk,
    input wire logic   i_reset,
    scb_bank_if.bank_side bus
);
    genvar g;
    generate
        for (g = 0; g < scb_pkg::BANKS; g++) begin : g_bank
            logic        open_q;
            logic [11:0] row_q;
            wire hit   = bus.bank == 2'(g);
            wire close = (bus.precharge & (bus.all_banks | hit))
                       | (bus.auto_precharge & (bus.auto_bank == 2'(g)));
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    open_q <= 1'b0;
                    row_q  <= 12'h000;
                end else if (bus.activate && hit) begin
                    open_q <= 1'b1;
                    row_q  <= bus.row;
                end else if (close) begin
                    open_q <= 1'b0;
                end
            end
            assign bus.active[g]   = open_q;
            assign bus.open_row[g] = row_q;
        end
    endgenerate
endmodule // scb_bank_table

/* core/scb_command_pins.sv */
// SDRAM command, address and byte-mask pin logic
module scb_command_pins (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_clock_gate,
    input  wire logic        i_select_n,
    input  wire logic        i_row_strobe_n,
    input  wire logic        i_col_strobe_n,
    input  wire logic        i_write_strobe_n,
    input  wire logic [11:0] i_address_bus,
    input  wire logic        i_bank_select_low,
    input  wire logic        i_bank_select_high,
    input  wire logic        i_low_byte_mask,
    input  wire logic        i_high_byte_mask,
    input  wire logic [15:0] i_data_lines,
    output logic      [15:0] o_data_lines,
    output logic      [15:0] o_data_lines_oe,
    input  wire logic [15:0] i_array_read_data,
    output logic             o_array_read,
    output logic             o_array_write,
    output logic      [1:0]  o_array_bank,
    output logic      [11:0] o_array_row,
    output logic      [7:0]  o_array_column,
    output logic      [15:0] o_array_write_data,
    output logic      [1:0]  o_array_byte_enable,
    output logic      [11:0] o_mode_register,
    output logic      [3:0]  o_power_state,
    output logic             o_refresh,
    output logic      [3:0]  o_bank_active
);
    scb_bank_if bank_bus ();

    scb_bank_table u_banks (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .bus     (bank_bus)
    );

    scb_pkg::scb_pins_type  pins_now;
    scb_pkg::scb_pins_type  pins_mid;
    scb_pkg::scb_pins_type  pins_q;
    scb_pkg::scb_state_type state;
    scb_pkg::scb_state_type next_state;
    logic        gate_meta;
    logic        gate_sync;
    logic [11:0] mode;
    logic        burst_on;
    logic        burst_write;
    logic        burst_auto;
    logic [1:0]  burst_bank;
    logic [7:0]  burst_start;
    logic [8:0]  burst_count;
    logic [8:0]  burst_len;
    logic [1:0]  mask_d1;
    logic [1:0]  rd_valid;
    logic [1:0][15:0] rd_data;

    assign pins_now = {i_select_n, i_row_strobe_n, i_col_strobe_n,
                       i_write_strobe_n, i_address_bus, i_bank_select_high,
                       i_bank_select_low, i_high_byte_mask, i_low_byte_mask,
                       i_data_lines};

    // Pins take a second stage so they stay aligned with the gate
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            gate_meta <= 1'b0;
            gate_sync <= 1'b0;
            pins_mid  <= scb_pkg::PINS_IDLE;
            pins_q    <= scb_pkg::PINS_IDLE;
        end else begin
            gate_meta <= i_clock_gate;
            gate_sync <= gate_meta;
            pins_mid  <= pins_now;
            pins_q    <= pins_mid;
        end
    end

    // Command decode
    wire       edge_valid = gate_sync;
    wire [2:0] cmd  = {pins_q.row_n, pins_q.col_n, pins_q.write_n};
    wire       take = edge_valid & ~pins_q.select_n;
    wire [1:0] bank = {pins_q.bank_high, pins_q.bank_low};
    wire       scope  = pins_q.address[scb_pkg::SCOPE_BIT];
    wire       is_lmr = take & (cmd == scb_pkg::CMD_LOAD_MODE);
    wire       is_ref = take & (cmd == scb_pkg::CMD_REFRESH);
    wire       is_pre = take & (cmd == scb_pkg::CMD_PRECHARGE);
    wire       is_act = take & (cmd == scb_pkg::CMD_ACTIVATE);
    wire       is_wr  = take & (cmd == scb_pkg::CMD_WRITE);
    wire       is_rd  = take & (cmd == scb_pkg::CMD_READ);
    wire       is_bst = take & (cmd == scb_pkg::CMD_BURST_STOP);
    // Access to an idle bank is dropped
    wire       start_cmd = (is_rd | is_wr) & bank_bus.active[bank];
    wire       stop_cmd  = is_bst
                         | (is_pre & (scope | bank == burst_bank));

    // Burst beat selection
    wire       single  = mode[scb_pkg::MODE_SINGLE_BIT];
    wire [8:0] mode_len = scb_pkg::scb_burst_len(
                              mode[scb_pkg::MODE_LEN_LSB +: 3]);
    wire [8:0] cmd_len  = (is_wr & single) ? scb_pkg::LEN_ONE : mode_len;
    wire       beat = start_cmd | (burst_on & edge_valid & ~stop_cmd);
    wire [8:0] beat_index = start_cmd ? 9'h000 : burst_count;
    wire [8:0] beat_len   = start_cmd ? cmd_len : burst_len;
    wire [7:0] beat_start = start_cmd ? pins_q.address[7:0]
                                      : burst_start;
    wire       beat_write = start_cmd ? is_wr : burst_write;
    wire       beat_auto  = start_cmd ? scope : burst_auto;
    wire [1:0] beat_bank  = start_cmd ? bank : burst_bank;
    wire [8:0] len_less   = beat_len - 9'h001;
    wire [7:0] wrap_mask  = len_less[7:0];
    wire [7:0] step = mode[scb_pkg::MODE_TYPE_BIT]
                    ? (beat_start ^ beat_index[7:0])
                    : (beat_start + beat_index[7:0]);
    wire [7:0] beat_col = (beat_start & ~wrap_mask) | (step & wrap_mask);
    // Full page keeps wrapping until stopped
    wire       beat_last = (beat_index + 9'h001 == beat_len)
                         & (beat_len != scb_pkg::LEN_FULL);

    // Bank table requests
    assign bank_bus.activate       = is_act;
    assign bank_bus.precharge      = is_pre;
    assign bank_bus.all_banks      = scope;
    assign bank_bus.bank           = bank;
    assign bank_bus.row            = pins_q.address;
    assign bank_bus.auto_precharge = beat & beat_last & beat_auto;
    assign bank_bus.auto_bank      = beat_bank;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode <= scb_pkg::MODE_RESET;
        end else if (is_lmr) begin
            mode <= pins_q.address;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            burst_on <= 1'b0;
        end else if (beat) begin
            burst_on <= ~beat_last;
        end else if (stop_cmd) begin
            burst_on <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            burst_write <= 1'b0;
            burst_auto  <= 1'b0;
            burst_bank  <= 2'h0;
            burst_start <= 8'h00;
            burst_count <= 9'h000;
            burst_len   <= scb_pkg::LEN_ONE;
        end else if (beat) begin
            burst_write <= beat_write;
            burst_auto  <= beat_auto;
            burst_bank  <= beat_bank;
            burst_start <= beat_start;
            burst_count <= beat_index + 9'h001;
            burst_len   <= beat_len;
        end
    end

    // Array port, one beat per valid edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_array_read        <= 1'b0;
            o_array_write       <= 1'b0;
            o_array_bank        <= 2'h0;
            o_array_row         <= 12'h000;
            o_array_column      <= 8'h00;
            o_array_write_data  <= 16'h0000;
            o_array_byte_enable <= 2'h0;
        end else begin
            o_array_read        <= beat & ~beat_write;
            o_array_write       <= beat & beat_write;
            o_array_bank        <= beat_bank;
            o_array_row         <= bank_bus.open_row[beat_bank];
            o_array_column      <= beat_col;
            o_array_write_data  <= pins_q.data;
            o_array_byte_enable <= ~{pins_q.high_mask,
                                     pins_q.low_mask};
        end
    end

    // Read return: in-flight data drains even while the clock is gated
    wire        lat_two   = mode[scb_pkg::MODE_LAT_LSB +: 3] ==
                            scb_pkg::LAT_TWO;
    wire        out_valid = lat_two ? rd_valid[0] : rd_valid[1];
    wire [15:0] out_data  = lat_two ? rd_data[0] : rd_data[1];
    wire [1:0]  lane_on   = {2{out_valid}} & ~mask_d1;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_valid <= 2'h0;
            rd_data  <= '0;
            mask_d1  <= 2'h3;
        end else begin
            rd_valid <= {rd_valid[0], o_array_read};
            rd_data  <= {rd_data[0], i_array_read_data};
            if (edge_valid) begin
                mask_d1 <= {pins_q.high_mask, pins_q.low_mask};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_data_lines    <= 16'h0000;
            o_data_lines_oe <= 16'h0000;
        end else begin
            o_data_lines    <= out_data;
            o_data_lines_oe <= {{8{lane_on[1]}}, {8{lane_on[0]}}};
        end
    end

    // Low-power state from the activity at the gated edge
    wire self_entry = ~pins_q.select_n & (cmd == scb_pkg::CMD_REFRESH);
    wire busy       = burst_on | (|rd_valid);
    scb_pkg::scb_state_type sleep_kind;
    assign sleep_kind = self_entry ? scb_pkg::ST_SELF_REFRESH
                      : busy       ? scb_pkg::ST_SUSPEND
                                   : scb_pkg::ST_POWER_DOWN;

    always_comb begin
        next_state = state;
        case (state)
            scb_pkg::ST_RUN: begin
                if (!edge_valid) next_state = sleep_kind;
            end
            scb_pkg::ST_POWER_DOWN,
            scb_pkg::ST_SUSPEND,
            scb_pkg::ST_SELF_REFRESH: begin
                if (edge_valid) next_state = scb_pkg::ST_RUN;
            end
            default: next_state = scb_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state     <= scb_pkg::ST_RUN;
            o_refresh <= 1'b0;
        end else begin
            state     <= next_state;
            o_refresh <= is_ref;
        end
    end

    assign o_mode_register = mode;
    assign o_power_state   = state;
    assign o_bank_active   = bank_bus.active;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_low_masked;
        edge_valid && pins_q.low_mask ##1 edge_valid;
    endsequence
    sequence s_high_masked;
        edge_valid && pins_q.high_mask ##1 edge_valid;
    endsequence

    a_pins_capture: assert property (
        !$past(i_reset) && !$past(i_reset, 2) |-> pins_q == $past(pins_now, 2))
        else $error("pins not captured two edges late");
    a_gate_sync: assert property (
        !$past(i_reset) && !$past(i_reset, 2)
        |-> gate_sync == $past(i_clock_gate, 2))
        else $error("clock gate sync path broken");
    a_frozen_edge: assert property (
        !edge_valid |=> $stable(mode) && $stable(burst_count))
        else $error("state moved on an ignored edge");
    a_sleep_state: assert property (
        !edge_valid && state == scb_pkg::ST_RUN && burst_on
        |=> state == scb_pkg::ST_SUSPEND)
        else $error("gated burst did not suspend");
    a_deselect_hold: assert property (
        edge_valid && pins_q.select_n |=> $stable(mode) && !o_refresh)
        else $error("deselected cycle acted");
    a_mode_load: assert property (
        is_lmr |=> mode == $past(pins_q.address))
        else $error("mode op-code not loaded");
    a_activate_row: assert property (
        is_act |=> bank_bus.active[$past(bank)]
                && bank_bus.open_row[$past(bank)] == $past(pins_q.address))
        else $error("activate did not open row");
    a_precharge_all: assert property (
        is_pre && scope |=> bank_bus.active == 4'h0)
        else $error("precharge all left a bank open");
    a_precharge_one: assert property (
        is_pre && !scope |=> !bank_bus.active[$past(bank)])
        else $error("selected bank not precharged");
    a_read_column: assert property (
        start_cmd && is_rd |=> o_array_read
            && o_array_column == $past(pins_q.address[7:0])
            && o_array_bank == $past(bank))
        else $error("read start column or bank wrong");
    a_write_mask: assert property (
        o_array_write |-> o_array_byte_enable ==
            ~$past({pins_q.high_mask, pins_q.low_mask}))
        else $error("masked write lane enabled");
    a_low_highz: assert property (
        s_low_masked |=> !o_data_lines_oe[0])
        else $error("low byte driven two cycles after mask");
    a_high_highz: assert property (
        s_high_masked |=> !o_data_lines_oe[8])
        else $error("high byte driven two cycles after mask");
    a_lane_split: assert property (
        o_data_lines_oe == {{8{o_data_lines_oe[8]}}, {8{o_data_lines_oe[0]}}})
        else $error("enable not uniform within a lane");
endmodule // scb_command_pins

/* tb/scb_ctrl_model.sv */
// Behavioural memory controller driving the command and data pins
module scb_ctrl_model (
    input  wire logic             i_clk,
    output scb_pkg::scb_pins_type o_pins,
    output logic                  o_clock_gate
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] last_data;

    initial begin
        o_pins       = scb_pkg::PINS_IDLE;
        o_clock_gate = 1'b1;
        last_data    = 16'h0000;
    end

    // One command cycle, then deselect with optional masks
    task automatic issue(input logic sel_n, input logic [2:0] code,
                         input logic [11:0] addr, input logic [1:0] bank,
                         input logic [1:0] mask, input logic [15:0] data,
                         input logic gate, input logic [1:0] next_mask);
        scb_pkg::scb_pins_type p;
        p = scb_pkg::PINS_IDLE;
        p.select_n = sel_n;
        {p.row_n, p.col_n, p.write_n} = code;
        p.address = addr;
        {p.bank_high, p.bank_low} = bank;
        {p.high_mask, p.low_mask} = mask;
        p.data = data;
        @(posedge i_clk);
        o_pins <= p;
        o_clock_gate <= gate;
        last_data = data;
        @(posedge i_clk);
        p = scb_pkg::PINS_IDLE;
        {p.high_mask, p.low_mask} = next_mask;
        // Released lines must not keep showing the old value
        p.data = ~last_data;
        o_pins <= p;
    endtask

    task automatic set_gate(input logic gate);
        @(posedge i_clk);
        o_clock_gate <= gate;
        @(posedge i_clk);
    endtask
endmodule // scb_ctrl_model

/* tb/scb_command_pins_tb.sv */
// Self-checking bench for the SDRAM command pin block
module scb_command_pins_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk;
    logic                  reset;
    scb_pkg::scb_pins_type pins;
    logic                  gate;
    logic [15:0]           data_out;
    logic [15:0]           data_oe;
    logic [15:0]           rd_data;
    logic                  arr_rd;
    logic                  arr_wr;
    logic [1:0]            arr_bank;
    logic [11:0]           arr_row;
    logic [7:0]            arr_col;
    logic [15:0]           arr_wdata;
    logic [1:0]            arr_be;
    logic [11:0]           mode;
    logic [3:0]            pstate;
    logic                  refresh;
    logic [3:0]            active;
    int                    mismatches = 0;
    int                    n_checks = 0;

    // Array model: read data names its own location
    assign rd_data = {4'hA, arr_col, arr_bank, 2'h0};

    scb_ctrl_model CTL (.i_clk(clk), .o_pins(pins), .o_clock_gate(gate));

    scb_command_pins DUT (
        .i_clk(clk), .i_reset(reset), .i_clock_gate(gate),
        .i_select_n(pins.select_n), .i_row_strobe_n(pins.row_n),
        .i_col_strobe_n(pins.col_n), .i_write_strobe_n(pins.write_n),
        .i_address_bus(pins.address), .i_bank_select_low(pins.bank_low),
        .i_bank_select_high(pins.bank_high), .i_low_byte_mask(pins.low_mask),
        .i_high_byte_mask(pins.high_mask), .i_data_lines(pins.data),
        .o_data_lines(data_out), .o_data_lines_oe(data_oe),
        .i_array_read_data(rd_data), .o_array_read(arr_rd),
        .o_array_write(arr_wr), .o_array_bank(arr_bank),
        .o_array_row(arr_row), .o_array_column(arr_col),
        .o_array_write_data(arr_wdata), .o_array_byte_enable(arr_be),
        .o_mode_register(mode), .o_power_state(pstate),
        .o_refresh(refresh), .o_bank_active(active));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Settle one nanosecond after the n-th following edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_run();
        for (int i = 0; i < 10 && pstate !== 4'h1; i++) step(1);
        chk(16'(pstate), 16'h0001);
    endtask

    task automatic t_mode();
        CTL.issue(1'b0, scb_pkg::CMD_LOAD_MODE, 12'h020, 2'h0, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        step(1);
        chk(16'(mode), 16'h0030);
        step(1);
        chk(16'(mode), 16'h0020);
        $display("test mode done");
    endtask

    task automatic t_activate();
        CTL.issue(1'b0, scb_pkg::CMD_ACTIVATE, 12'hABC, 2'h2, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        step(3);
        chk(16'(active), 16'h0004);
        CTL.issue(1'b1, scb_pkg::CMD_ACTIVATE, 12'h123, 2'h1, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        step(4);
        chk(16'(active), 16'h0004);
        $display("test activate done");
    endtask

    task automatic t_write();
        CTL.issue(1'b0, scb_pkg::CMD_WRITE, 12'h35A, 2'h2, 2'b10,
                  16'h1234, 1'b1, 2'h0);
        step(2);
        chk(16'(arr_wr), 16'h0001);
        chk(16'(arr_bank), 16'h0002);
        chk(16'(arr_row), 16'h0ABC);
        chk(16'(arr_col), 16'h005A);
        chk(arr_wdata, 16'h1234);
        chk(16'(arr_be), 16'h0001);
        step(1);
        chk(16'(arr_wr), 16'h0000);
        $display("test write done");
    endtask

    task automatic t_read();
        CTL.issue(1'b0, scb_pkg::CMD_READ, 12'h433, 2'h2, 2'h0,
                  16'h0000, 1'b1, 2'b01);
        step(2);
        chk(16'(arr_rd), 16'h0001);
        chk(16'(arr_col), 16'h0033);
        step(1);
        chk(data_oe, 16'h0000);
        step(1);
        chk(data_oe, 16'hFF00);
        chk(data_out & 16'hFF00, 16'hA300);
        chk(16'(active), 16'h0000);
        step(1);
        chk(data_oe, 16'h0000);
        $display("test read done");
    endtask

    task automatic t_precharge();
        CTL.issue(1'b0, scb_pkg::CMD_ACTIVATE, 12'h011, 2'h1, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        CTL.issue(1'b0, scb_pkg::CMD_ACTIVATE, 12'h022, 2'h3, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        step(3);
        chk(16'(active), 16'h000A);
        CTL.issue(1'b0, scb_pkg::CMD_PRECHARGE, 12'h000, 2'h3, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        step(3);
        chk(16'(active), 16'h0002);
        CTL.issue(1'b0, scb_pkg::CMD_PRECHARGE, 12'h400, 2'h0, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        step(3);
        chk(16'(active), 16'h0000);
        $display("test precharge done");
    endtask

    task automatic t_power();
        CTL.issue(1'b0, scb_pkg::CMD_REFRESH, 12'h000, 2'h0, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        step(2);
        chk(16'(refresh), 16'h0001);
        step(1);
        chk(16'(refresh), 16'h0000);
        // Command with gate low must be dropped
        CTL.issue(1'b0, scb_pkg::CMD_ACTIVATE, 12'h0F0, 2'h0, 2'h0,
                  16'h0000, 1'b0, 2'h0);
        step(3);
        chk(16'(pstate), 16'h0002);
        chk(16'(active), 16'h0000);
        CTL.set_gate(1'b1);
        wait_run();
        CTL.issue(1'b0, scb_pkg::CMD_REFRESH, 12'h000, 2'h0, 2'h0,
                  16'h0000, 1'b0, 2'h0);
        step(3);
        chk(16'(pstate), 16'h0008);
        CTL.set_gate(1'b1);
        wait_run();
        $display("test power done");
    endtask

    task automatic t_burst();
        CTL.issue(1'b0, scb_pkg::CMD_LOAD_MODE, 12'h022, 2'h0, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        CTL.issue(1'b0, scb_pkg::CMD_ACTIVATE, 12'h055, 2'h0, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        CTL.issue(1'b0, scb_pkg::CMD_READ, 12'h010, 2'h0, 2'h0,
                  16'h0000, 1'b1, 2'h0);
        // Gate drops after two beats of the four-beat burst
        CTL.set_gate(1'b0);
        step(2);
        chk(16'(pstate), 16'h0004);
        chk(16'(arr_rd), 16'h0000);
        CTL.set_gate(1'b1);
        wait_run();
        chk(16'(arr_rd), 16'h0001);
        chk(16'(arr_col), 16'h0012);
        step(1);
        chk(16'(arr_col), 16'h0013);
        step(1);
        chk(16'(arr_rd), 16'h0000);
        $display("test burst done");
    endtask

    initial begin
        reset = 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(16'(mode), 16'(scb_pkg::MODE_RESET));
        chk(16'(pstate), 16'h0001);
        chk(16'(active), 16'h0000);
        $display("test reset done");
        t_mode();
        t_activate();
        t_write();
        t_read();
        t_precharge();
        t_power();
        t_burst();
        final_report();
    end

    // Whole run is about 90 cycles
    initial begin
        repeat (1000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule // scb_command_pins_tb
